// *** scbg_rate_divider.sv ***
/*
 * Holds the shared constants of the serial baud clock generator and the
 * divider that counts reference clock ticks down to the 16X rate clock.
 * Assumes a single system clock; the reference arrives as a one-cycle tick.
 */
`timescale 1ns/1ps

// ***************************************************************
// Shared constants
// ***************************************************************
package scbg_pkg;
   localparam int           DIV_W       = 13;        // Widest divisor is 6336
   localparam int           RATE_W      = 4;         // Sixteen selectable rates
   localparam int           PRE_W       = 4;         // 16X prescaler width
   localparam logic [3:0]   PRE_LAST    = 4'hf;      // Sixteenth sample of a bit
   localparam logic [3:0]   PRE_RESET   = 4'h0;      // Prescaler after reset
   localparam logic [3:0]   RATE_RESET  = 4'h0;      // Rate code after reset
   localparam logic [12:0]  CNT_RESET   = 13'h0000;  // Divider count after reset
   // Divisors per rate code
   localparam logic [12:0]  DIV_50      = 13'd6336;
   localparam logic [12:0]  DIV_75      = 13'd4224;
   localparam logic [12:0]  DIV_110     = 13'd2880;
   localparam logic [12:0]  DIV_134     = 13'd2355;
   localparam logic [12:0]  DIV_150     = 13'd2112;
   localparam logic [12:0]  DIV_300     = 13'd1056;
   localparam logic [12:0]  DIV_600     = 13'd528;
   localparam logic [12:0]  DIV_1200    = 13'd264;
   localparam logic [12:0]  DIV_1800    = 13'd176;
   localparam logic [12:0]  DIV_2000    = 13'd158;
   localparam logic [12:0]  DIV_2400    = 13'd132;
   localparam logic [12:0]  DIV_3600    = 13'd88;
   localparam logic [12:0]  DIV_4800    = 13'd66;
   localparam logic [12:0]  DIV_7200    = 13'd44;
   localparam logic [12:0]  DIV_9600    = 13'd33;
   localparam logic [12:0]  DIV_19200   = 13'd16;

   // Rate code to divisor
   function automatic logic [12:0] scbg_divisor(input logic [3:0] code);
      case (code)
         4'h0:    scbg_divisor = DIV_50;
         4'h1:    scbg_divisor = DIV_75;
         4'h2:    scbg_divisor = DIV_110;
         4'h3:    scbg_divisor = DIV_134;
         4'h4:    scbg_divisor = DIV_150;
         4'h5:    scbg_divisor = DIV_300;
         4'h6:    scbg_divisor = DIV_600;
         4'h7:    scbg_divisor = DIV_1200;
         4'h8:    scbg_divisor = DIV_1800;
         4'h9:    scbg_divisor = DIV_2000;
         4'ha:    scbg_divisor = DIV_2400;
         4'hb:    scbg_divisor = DIV_3600;
         4'hc:    scbg_divisor = DIV_4800;
         4'hd:    scbg_divisor = DIV_7200;
         4'he:    scbg_divisor = DIV_9600;
         default: scbg_divisor = DIV_19200;
      endcase
   endfunction : scbg_divisor
endpackage : scbg_pkg

// ***************************************************************
// Reference tick divider
// ***************************************************************
module scbg_rate_divider
   import scbg_pkg::*;
(
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               reset,
   // Reference tick and divisor
   input  wire logic               ref_tick,
   input  wire logic [DIV_W-1:0]   divisor,
   // Divided clock
   output logic                    rate_tick,
   output logic                    rate_level
);
   logic [DIV_W-1:0] cnt_r, cnt_nxt;     // Reference ticks in this period
   logic             tick_r, tick_nxt;   // End of period pulse
   logic             lvl_r, lvl_nxt;     // Square wave for the pin

   // Next count, wraps at divisor minus one
   always_comb begin
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (ref_tick) begin
         if (cnt_r >= divisor - 13'd1) begin
            cnt_nxt  = CNT_RESET;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 13'd1;
         end
      end
      lvl_nxt = (cnt_nxt < (divisor >> 1));
   end

   // Register the divider state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_r  <= CNT_RESET;
         tick_r <= 1'b0;
         lvl_r  <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
         lvl_r  <= lvl_nxt;
      end
   end

   assign rate_tick  = tick_r;
   assign rate_level = lvl_r;
endmodule : scbg_rate_divider

// *** scbg_baud_clock.sv ***
/*
 * Timing section of the serial controller: selects external or divided
 * bit clocks for transmitter and receiver and applies the 16X or 1X
 * multiplier. Assumes the mode write strobe is on ref_clk and that the
 * pins reference_clock_in and both bit clocks are asynchronous.
 */
// Functional notes
// RULE_01: Divide reference by fixed per-rate divisor
// RULE_02: Asynchronous mode uses sixteen samples per bit
// RULE_03: Synchronous mode uses one clock per bit
// RULE_04: Choose external bit clocks or divided reference
// RULE_05: One selected rate clocks both directions
// RULE_06: Fit 4.9152 MHz crystal for exact 19200
// RULE_07: Master reset clears mode and idles everything
// RULE_08: Four-bit rate field in written mode register

`timescale 1ns/1ps

module scbg_baud_clock
   import scbg_pkg::*;
(
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               reset,
   // Mode register write
   input  wire logic               mode_wr,
   input  wire logic [RATE_W-1:0]  mode_rate_in,
   input  wire logic               mode_async_in,
   input  wire logic               mode_int_tx_in,
   input  wire logic               mode_int_rx_in,
   // Reference pin
   input  wire logic               reference_clock_in,
   // Transmit bit clock pin
   input  wire logic               transmit_bit_clock_i,
   output logic                    transmit_bit_clock_o,
   output logic                    transmit_bit_clock_oe,
   // Receive bit clock pin
   input  wire logic               receive_bit_clock_i,
   output logic                    receive_bit_clock_o,
   output logic                    receive_bit_clock_oe,
   // Ticks to the serial logic
   output logic                    tx_sample_tick,
   output logic                    tx_bit_tick,
   output logic                    rx_sample_tick,
   output logic                    rx_bit_tick
);
   // ***************************************************************
   // Pin synchronisers and edge detect
   // ***************************************************************
   logic [2:0] pin_in;         // Reference, transmit, receive pins
   logic [2:0] s1_r, s1_nxt;   // First stage
   logic [2:0] s2_r, s2_nxt;   // Second stage
   logic [2:0] s3_r, s3_nxt;   // Previous second stage
   logic [2:0] rise;           // Rising edges of the pins

   assign pin_in = {receive_bit_clock_i, transmit_bit_clock_i, reference_clock_in};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         // Shift one pin through its stages
         always_comb begin
            s1_nxt[g] = pin_in[g];
            s2_nxt[g] = s1_r[g];
            s3_nxt[g] = s2_r[g];
            rise[g]   = s2_r[g] & ~s3_r[g];
         end
      end
   endgenerate

   // Register the synchroniser stages
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
         s3_r <= 3'h0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end

   // ***************************************************************
   // Mode register
   // ***************************************************************
   logic [RATE_W-1:0] rate_r, rate_nxt;       // Selected rate code
   logic              async_r, async_nxt;     // 16X multiplier when set
   logic              int_tx_r, int_tx_nxt;   // Transmit clock from divider
   logic              int_rx_r, int_rx_nxt;   // Receive clock from divider

   // Load all mode fields on a write
   always_comb begin
      rate_nxt   = rate_r;
      async_nxt  = async_r;
      int_tx_nxt = int_tx_r;
      int_rx_nxt = int_rx_r;
      if (mode_wr) begin
         rate_nxt   = mode_rate_in;    // RULE_08
         async_nxt  = mode_async_in;
         int_tx_nxt = mode_int_tx_in;
         int_rx_nxt = mode_int_rx_in;
      end
   end

   // Reset clears the mode and idles the block
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rate_r   <= RATE_RESET;   // RULE_07
         async_r  <= 1'b0;
         int_tx_r <= 1'b0;
         int_rx_r <= 1'b0;
      end else begin
         rate_r   <= rate_nxt;
         async_r  <= async_nxt;
         int_tx_r <= int_tx_nxt;
         int_rx_r <= int_rx_nxt;
      end
   end

   // ***************************************************************
   // Rate divider
   // ***************************************************************
   logic [DIV_W-1:0] divisor;      // Divisor for the selected code
   logic             gen_tick;     // Divided clock period pulse
   logic             gen_level;    // Divided clock square wave

   assign divisor = scbg_divisor(rate_r);   // RULE_01

   scbg_rate_divider u_rate_divider (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .ref_tick   (rise[0]),
      .divisor    (divisor),
      .rate_tick  (gen_tick),
      .rate_level (gen_level)
   );

   // ***************************************************************
   // Per direction source select and multiplier
   // ***************************************************************
   logic [1:0]       use_int;               // Divider feeds this direction
   logic [1:0]       src_tick;              // Chosen clock edge
   logic [PRE_W-1:0] pre_r [2];             // Samples within the bit
   logic [PRE_W-1:0] pre_nxt [2];
   logic [1:0]       samp_r, samp_nxt;      // Sample tick out
   logic [1:0]       bit_r, bit_nxt;        // Bit tick out
   logic [1:0]       pin_o_r, pin_o_nxt;    // Pin drive level
   logic [1:0]       pin_oe_r, pin_oe_nxt;  // Pin drive enable

   assign use_int = {int_rx_r, int_tx_r};

   generate
      for (g = 0; g < 2; g++) begin : g_dir
         // Pick source, then count sixteen or one per bit
         always_comb begin
            src_tick[g]   = use_int[g] ? gen_tick : rise[g+1];   // RULE_04 RULE_05
            pre_nxt[g]    = pre_r[g];
            samp_nxt[g]   = src_tick[g];
            bit_nxt[g]    = 1'b0;
            pin_o_nxt[g]  = use_int[g] & gen_level;
            pin_oe_nxt[g] = use_int[g];
            if (src_tick[g]) begin
               if (!async_r) begin
                  bit_nxt[g] = 1'b1;               // RULE_03
                  pre_nxt[g] = PRE_RESET;
               end else if (pre_r[g] == PRE_LAST) begin
                  bit_nxt[g] = 1'b1;               // RULE_02
                  pre_nxt[g] = PRE_RESET;
               end else begin
                  pre_nxt[g] = pre_r[g] + 4'h1;
               end
            end
         end

         // Register this direction
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               pre_r[g]    <= PRE_RESET;           // RULE_07
               samp_r[g]   <= 1'b0;
               bit_r[g]    <= 1'b0;
               pin_o_r[g]  <= 1'b0;
               pin_oe_r[g] <= 1'b0;
            end else begin
               pre_r[g]    <= pre_nxt[g];
               samp_r[g]   <= samp_nxt[g];
               bit_r[g]    <= bit_nxt[g];
               pin_o_r[g]  <= pin_o_nxt[g];
               pin_oe_r[g] <= pin_oe_nxt[g];
            end
         end
      end
   endgenerate

   assign tx_sample_tick        = samp_r[0];
   assign tx_bit_tick           = bit_r[0];
   assign rx_sample_tick        = samp_r[1];
   assign rx_bit_tick           = bit_r[1];
   assign transmit_bit_clock_o  = pin_o_r[0];
   assign transmit_bit_clock_oe = pin_oe_r[0];
   assign receive_bit_clock_o   = pin_o_r[1];
   assign receive_bit_clock_oe  = pin_oe_r[1];

   // ***************************************************************
   // Assertions
   // ***************************************************************
   logic [4:0] tx_gap_r;   // Sample ticks since last transmit bit tick

   // Count transmit samples between bit ticks
   always_ff @(posedge ref_clk) begin
      if (reset || tx_bit_tick) begin
         tx_gap_r <= 5'h00;
      end else if (tx_sample_tick) begin
         tx_gap_r <= tx_gap_r + 5'h01;
      end
   end

   sequence s_mode_loaded;
      mode_wr ##1 !mode_wr;
   endsequence

   a_div_table: assert property (@(posedge ref_clk) disable iff (reset)   // RULE_01
      (rate_r == 4'h0 |-> divisor == 13'd6336) and
      (rate_r == 4'h3 |-> divisor == 13'd2355) and
      (rate_r == 4'ha |-> divisor == 13'd132))
      else $error("divisor does not match rate code");

   a_async_sixteen: assert property (@(posedge ref_clk) disable iff (reset)   // RULE_02
      tx_bit_tick && async_r && $past(async_r, 40) && tx_gap_r != 5'h00
      |-> tx_gap_r == 5'd15)
      else $error("async bit tick not after sixteen samples");

   a_sync_one: assert property (@(posedge ref_clk) disable iff (reset)   // RULE_03
      !async_r && $past(!async_r) && tx_sample_tick |-> tx_bit_tick)
      else $error("sync sample without bit tick");

   a_src_select: assert property (@(posedge ref_clk) disable iff (reset)   // RULE_04
      (!int_tx_r && !rise[1]) |=> (!tx_sample_tick && !transmit_bit_clock_oe))
      else $error("external mode ticked without pin edge");

   a_both_dirs: assert property (@(posedge ref_clk) disable iff (reset)   // RULE_05
      (int_tx_r && int_rx_r) |=> (tx_sample_tick == rx_sample_tick))
      else $error("directions differ on shared rate");

   a_reset_clear: assert property (@(posedge ref_clk)   // RULE_07
      reset |=> (rate_r == 4'h0 && !async_r && !int_tx_r && !tx_sample_tick
                 && !rx_bit_tick && !receive_bit_clock_oe))
      else $error("reset did not clear the mode");

   a_mode_write: assert property (@(posedge ref_clk) disable iff (reset)   // RULE_08
      s_mode_loaded |-> rate_r == $past(mode_rate_in, 1) && divisor == scbg_divisor(rate_r))
      else $error("rate field not loaded from write");
endmodule : scbg_baud_clock

// *** scbg_serial_model.sv ***
/*
 * Stand-in for the serial transmitter and receiver and the board clocks.
 * Assumes ref_clk is the system clock; clocks it makes park low at zero.
 */
`timescale 1ns/1ps

// ***************************************************************
// Board clocks and tick consumer
// ***************************************************************
module scbg_serial_model (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         reset,
   // Half periods in ref_clk cycles
   input  wire logic [7:0]   ref_half,
   input  wire logic [7:0]   tx_half,
   input  wire logic [7:0]   rx_half,
   // Ticks from the timing section
   input  wire logic         tx_sample_tick,
   input  wire logic         tx_bit_tick,
   input  wire logic         rx_sample_tick,
   input  wire logic         rx_bit_tick,
   // Clocks towards the pins
   output logic              reference_clock_in,
   output logic              tx_clk_drv,
   output logic              rx_clk_drv,
   // Samples seen in the last whole bit
   output logic [7:0]        tx_per_bit,
   output logic [7:0]        rx_per_bit
);
   logic [7:0] half [3];        // Half period per clock
   logic [7:0] cnt [3];         // Half period counters
   logic [2:0] clk_q = 3'h0;    // Clock levels
   logic [7:0] tx_run, rx_run;  // Samples in current bit

   assign half[0] = ref_half;
   assign half[1] = tx_half;
   assign half[2] = rx_half;
   assign reference_clock_in = clk_q[0];  // Crystal stand-in; exact 19200 needs 4.9152 MHz
   assign tx_clk_drv = clk_q[1];
   assign rx_clk_drv = clk_q[2];

   // Square waves, stand still low when half period is zero
   always @(posedge ref_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (half[i] == 8'h00) begin
            clk_q[i] <= 1'b0;
            cnt[i]   <= 8'h00;
         end else if (cnt[i] >= half[i] - 8'h01) begin
            clk_q[i] <= ~clk_q[i];
            cnt[i]   <= 8'h00;
         end else begin
            cnt[i] <= cnt[i] + 8'h01;
         end
      end
   end

   // Count sample ticks per bit in each direction
   always @(posedge ref_clk) begin
      if (reset) begin
         tx_run     <= 8'h00;
         rx_run     <= 8'h00;
         tx_per_bit <= 8'h00;
         rx_per_bit <= 8'h00;
      end else begin
         if (tx_sample_tick) tx_run <= tx_bit_tick ? 8'h00 : tx_run + 8'h01;
         if (tx_bit_tick) tx_per_bit <= tx_run + 8'h01;
         if (rx_sample_tick) rx_run <= rx_bit_tick ? 8'h00 : rx_run + 8'h01;
         if (rx_bit_tick) rx_per_bit <= rx_run + 8'h01;
      end
   end
endmodule : scbg_serial_model

// *** serial_baud_clock_generator_tb.sv ***
/*
 * Self-checking bench for the baud clock timing section.
 * Assumes the serial model file is compiled before this one.
 */
`timescale 1ns/1ps

module serial_baud_clock_generator_tb;
   import scbg_pkg::*;
   logic              ref_clk, reset, mode_wr;                 // Clock, reset, strobe
   logic              mode_async_in, mode_int_tx_in, mode_int_rx_in;  // Mode fields
   logic [RATE_W-1:0] mode_rate_in;                            // Rate code
   logic [7:0]        ref_half, tx_half, rx_half;              // Board clock settings
   logic              ref_pin, tx_drv, rx_drv, tx_o, tx_oe, rx_o, rx_oe;  // Pin side
   logic              tx_s, tx_b, rx_s, rx_b;                  // Ticks
   logic [7:0]        tx_pb, rx_pb;                            // Samples per bit
   int                errors, n_compared;                      // Tallies
   wire               tx_pin = tx_oe ? tx_o : tx_drv;          // Resolved pins
   wire               rx_pin = rx_oe ? rx_o : rx_drv;

   scbg_baud_clock dut (.ref_clk(ref_clk), .reset(reset), .mode_wr(mode_wr),
      .mode_rate_in(mode_rate_in), .mode_async_in(mode_async_in),
      .mode_int_tx_in(mode_int_tx_in), .mode_int_rx_in(mode_int_rx_in),
      .reference_clock_in(ref_pin), .transmit_bit_clock_i(tx_pin),
      .transmit_bit_clock_o(tx_o), .transmit_bit_clock_oe(tx_oe),
      .receive_bit_clock_i(rx_pin), .receive_bit_clock_o(rx_o),
      .receive_bit_clock_oe(rx_oe), .tx_sample_tick(tx_s), .tx_bit_tick(tx_b),
      .rx_sample_tick(rx_s), .rx_bit_tick(rx_b));

   scbg_serial_model model (.ref_clk(ref_clk), .reset(reset), .ref_half(ref_half),
      .tx_half(tx_half), .rx_half(rx_half), .tx_sample_tick(tx_s), .tx_bit_tick(tx_b),
      .rx_sample_tick(rx_s), .rx_bit_tick(rx_b), .reference_clock_in(ref_pin),
      .tx_clk_drv(tx_drv), .rx_clk_drv(rx_drv), .tx_per_bit(tx_pb), .rx_per_bit(rx_pb));

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
      end
   endtask : chk

   // Tick selector: 0 tx sample, 1 tx bit, 2 rx sample, 3 rx bit
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = tx_s;
         1: pick = tx_b;
         2: pick = rx_s;
         default: pick = rx_b;
      endcase
   endfunction : pick

   // Cycles until the next tick, bounded
   task automatic next_tick(input int sel, output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (pick(sel) !== 1'b1 && n < 20000);
      if (n >= 20000) chk(32'h0, 32'h1, "tick never came");
   endtask : next_tick

   // One full spacing between two ticks
   task automatic gap(input int sel, output int n);
      next_tick(sel, n);
      next_tick(sel, n);
   endtask : gap

   task automatic write_mode(input logic [3:0] rate, input logic asy, itx, irx);
      @(negedge ref_clk);
      mode_rate_in = rate;
      mode_async_in = asy;
      mode_int_tx_in = itx;
      mode_int_rx_in = irx;
      mode_wr = 1'b1;
      @(negedge ref_clk);
      mode_wr = 1'b0;
   endtask : write_mode

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_divisors;
      logic [3:0] codes [3] = '{4'hf, 4'ha, 4'h3};
      int         div [3] = '{16, 132, 2355};
      int         n;
      ref_half = 8'd3;
      foreach (codes[i]) begin
         write_mode(codes[i], 1'b1, 1'b1, 1'b1);
         gap(0, n);
         chk(n, div[i] * 6, "sample spacing");
         chk({rx_s, tx_oe, rx_oe}, 3'h7, "both internal");
         chk({tx_o, rx_o}, 2'h3, "pins high after wrap");
         // Second half of the divided period drives the pins low
         repeat (div[i] * 3 + 3) @(negedge ref_clk);
         chk({tx_o, rx_o}, 2'h0, "pins low in second half");
      end
   endtask : t_divisors

   task automatic t_multiplier;
      int n;
      write_mode(4'hf, 1'b1, 1'b1, 1'b1);
      repeat (3) next_tick(1, n);
      chk(tx_pb, 16, "async tx samples per bit");
      chk(rx_pb, 16, "async rx samples per bit");
      write_mode(4'hf, 1'b0, 1'b1, 1'b1);
      repeat (3) next_tick(1, n);
      chk(n, 96, "sync bit spacing");
      chk(tx_pb, 1, "sync samples per bit");
   endtask : t_multiplier

   task automatic t_external;
      int n;
      write_mode(4'h0, 1'b1, 1'b0, 1'b0);
      tx_half = 8'd4;
      rx_half = 8'd5;
      // Let edges left over from the driven pins drain first
      repeat (20) @(negedge ref_clk);
      gap(0, n);
      chk(n, 8, "tx pin clock spacing");
      gap(2, n);
      chk(n, 10, "rx pin clock spacing");
      chk({tx_oe, rx_oe}, 2'h0, "pins not driven");
      repeat (3) next_tick(1, n);
      chk(tx_pb, 16, "external samples per bit");
      // Mixed sources: transmit from its pin in 1X, receive from divider
      write_mode(4'h0, 1'b0, 1'b0, 1'b1);
      gap(1, n);
      chk(n, 8, "sync pin bit spacing");
      chk({tx_oe, rx_oe}, 2'h1, "only receive pin driven");
      tx_half = 8'd0;
      rx_half = 8'd0;
   endtask : t_external

   task automatic t_mid_reset;
      int hits = 0;
      write_mode(4'hf, 1'b0, 1'b1, 1'b1);
      repeat (200) @(negedge ref_clk);
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      chk({tx_oe, rx_oe}, 2'h0, "mode cleared");
      repeat (300) begin
         @(negedge ref_clk);
         if (tx_s === 1'b1 || rx_s === 1'b1) hits++;
      end
      chk(hits, 0, "ticks after reset");
   endtask : t_mid_reset

   task automatic print_verdict;
      if (errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // Clock, 4 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Watchdog well beyond the expected run
   initial begin
      #240000;
      errors++;
      print_verdict;
   end

   // Main sequence
   initial begin
      errors = 0;
      n_compared = 0;
      reset = 1'b1;
      mode_wr = 1'b0;
      mode_rate_in = 4'h0;
      mode_async_in = 1'b0;
      mode_int_tx_in = 1'b0;
      mode_int_rx_in = 1'b0;
      ref_half = 8'h00;
      tx_half = 8'h00;
      rx_half = 8'h00;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      chk({tx_oe, rx_oe, tx_s, tx_b, rx_s, rx_b}, 6'h00, "outputs after reset");
      t_divisors;
      t_multiplier;
      t_external;
      t_mid_reset;
      print_verdict;
   end
endmodule : serial_baud_clock_generator_tb
